// [hw/hv_mon_map.svh]
// offsets, field positions, reset values and timing counts for the hv monitor
`ifndef HV_MON_MAP_SVH
`define HV_MON_MAP_SVH

// ---------------------------------------------------------------------------
// register selectors and resets
// ---------------------------------------------------------------------------
`define HV_SEL_LIVE_MONITOR 1'h0
`define HV_SEL_EVENT_STATUS 1'h1
`define HV_LIVE_MONITOR_RST 8'h00
`define HV_EVENT_STATUS_RST 8'h00

// ---------------------------------------------------------------------------
// live monitor bit positions
// ---------------------------------------------------------------------------
`define HV_MON_WAKE_BIT 7
`define HV_MON_THERM_BIT 6
`define HV_MON_AUX_BIT 5
`define HV_MON_BUF_BIT 4
`define HV_MON_LOWSUP_BIT 3
`define HV_MON_BUS_SC_BIT 2
`define HV_MON_AUX_SC_BIT 1
`define HV_MON_WAKE_SC_BIT 0

// ---------------------------------------------------------------------------
// event status bit positions
// ---------------------------------------------------------------------------
`define HV_STA_SUPPLY_BIT 5
`define HV_STA_WAKE_EDGE_BIT 4
`define HV_STA_THERM_BIT 3
`define HV_STA_BUS_SC_BIT 2
`define HV_STA_AUX_SC_BIT 1
`define HV_STA_WAKE_SC_BIT 0

// ---------------------------------------------------------------------------
// timing: busy time of the automatic status transfer
// ---------------------------------------------------------------------------
`define HV_CLK_PERIOD_NS 10
`define HV_XFER_TIME_US 10
`define HV_XFER_CYCLES ((`HV_XFER_TIME_US * 1000) / `HV_CLK_PERIOD_NS)
`define HV_XFER_CNT_W 10

`endif

// [hw/hv_mon_pkg.sv]
// types for the high-voltage monitor and status register pair
package hv_mon_pkg;

  // fault and event inputs from the supervisory circuits
  typedef struct packed {
    logic thermal;
    logic bus_short;
    logic aux_short;
    logic wake_short;
    logic supply_low;
  } hv_fault_type;

  // configuration bits steering the block
  typedef struct packed {
    logic input_mode;
    logic low_flag_en;
    logic supply_mon_en;
    logic buf_en;
  } hv_cfg_type;

  // driver enables toward the pin drivers
  typedef struct packed {
    logic bus_drv;
    logic wake_drv;
    logic aux_drv;
  } hv_drv_type;

  // automatic transfer state
  typedef enum logic [1:0] {
    xfer_idle,
    xfer_busy
  } hv_xfer_type;

endpackage

// [hw/hv_edge_detect.sv]
// edge detector for the wake and aux input lines
module hv_edge_detect (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] line_in,
  output logic [1:0] edge_out
);

  logic [1:0] prev_r;

  // one stage per line, reports any change
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          prev_r[gi] <= 1'b0;
        end else begin
          prev_r[gi] <= line_in[gi];
        end
      end
      assign edge_out[gi] = prev_r[gi] ^ line_in[gi];
    end
  endgenerate

endmodule // hv_edge_detect

// [hw/hv_monitor_status_regs.sv]
// live monitor and event status registers of the high-voltage interface
//
// How it works
// - live monitor: 8 bits, read-only, indirect
// - monitor bit 7 follows wake line in input mode, else 0
// - monitor bit 5 follows aux line in input mode, else 0
// - monitor bit 4 shows buffer enable
// - bit 3 low-supply flag, supply loss clears
// - bits 2,1 driver shorts, re-enable clears
// - bit 0 flags wake driver short
// - status: 8 bits, records fault, supply and wake events
// - interrupt copies status into data port
// - status bit 5 unlatched supply monitor
// - status bit 4 on wake edge in input mode
// - status bit 3 thermal, monitor bit 6
// - thermal disables all three drivers
// - bus short sets bit 2, disables
// - aux short sets bit 1, read clears
// - wake short sets status bit 0
// - wake line reached only through ports
// - busy set, cleared after 10 us
// - input mode edges raise interrupt
// - re-enable bit restores drivers, self-clears
`include "hv_mon_map.svh"

module hv_monitor_status_regs
  import hv_mon_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire hv_cfg_type cfg_in,
  input wire hv_fault_type fault_in,
  input wire logic wake_line_in,
  input wire logic aux_hv_line_in,
  input wire logic core_supply_ok_in,
  input wire logic drv_reenable_in,
  input wire logic irq_enable_in,
  input wire logic rd_req_in,
  input wire logic rd_sel_in,
  output hv_drv_type drv_en_out,
  output logic [7:0] hv_data_port_out,
  output logic busy_out,
  output logic xfer_ok_out,
  output logic hv_irq_line_out,
  output logic reenable_bit_out
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [7:0] mon_r;
  logic [7:0] sta_r;
  logic [7:0] sta_nxt;
  logic lowsup_r;
  logic low_en_d_r;
  logic bus_sc_r;
  logic aux_sc_r;
  logic wake_sc_r;
  logic therm_r;
  logic [1:0] line_edge;
  logic sta_rd;
  logic event_any;
  logic [`HV_XFER_CNT_W-1:0] cnt_r;
  hv_xfer_type xfer_r;

  hv_edge_detect u_edge (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .line_in({wake_line_in, aux_hv_line_in}),
    .edge_out(line_edge)
  );

  // status read by software, only when no transfer runs
  assign sta_rd = rd_req_in && (rd_sel_in == `HV_SEL_EVENT_STATUS)
                  && (xfer_r == xfer_idle);

  // -------------------------------------------------------------------------
  // sticky fault flags for the live monitor
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_sc_r <= 1'b0;
      aux_sc_r <= 1'b0;
      wake_sc_r <= 1'b0;
      therm_r <= 1'b0;
    end else begin
      // fault set wins over re-enable clear
      bus_sc_r <= fault_in.bus_short | (bus_sc_r & ~drv_reenable_in);
      aux_sc_r <= fault_in.aux_short | (aux_sc_r & ~drv_reenable_in);
      wake_sc_r <= fault_in.wake_short | (wake_sc_r & ~drv_reenable_in);
      therm_r <= fault_in.thermal | (therm_r & ~drv_reenable_in);
    end
  end

  // low-supply flag, armed on enable, dropped by supply loss
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lowsup_r <= 1'b0;
      low_en_d_r <= 1'b0;
    end else begin
      low_en_d_r <= cfg_in.low_flag_en;
      if (!cfg_in.low_flag_en) begin
        lowsup_r <= 1'b0;
      end else if (!low_en_d_r) begin
        lowsup_r <= core_supply_ok_in;
      end else if (!core_supply_ok_in) begin
        lowsup_r <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // live monitor register
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mon_r <= `HV_LIVE_MONITOR_RST;
    end else begin
      mon_r[`HV_MON_WAKE_BIT] <= cfg_in.input_mode & wake_line_in;
      mon_r[`HV_MON_THERM_BIT] <= therm_r;
      mon_r[`HV_MON_AUX_BIT] <= cfg_in.input_mode & aux_hv_line_in;
      mon_r[`HV_MON_BUF_BIT] <= cfg_in.buf_en;
      mon_r[`HV_MON_LOWSUP_BIT] <= lowsup_r;
      mon_r[`HV_MON_BUS_SC_BIT] <= bus_sc_r;
      mon_r[`HV_MON_AUX_SC_BIT] <= aux_sc_r;
      mon_r[`HV_MON_WAKE_SC_BIT] <= wake_sc_r;
    end
  end

  // -------------------------------------------------------------------------
  // event status register
  // -------------------------------------------------------------------------
  always_comb begin
    sta_nxt = sta_r;
    if (sta_rd) begin
      sta_nxt[`HV_STA_BUS_SC_BIT] = 1'b0;
      sta_nxt[`HV_STA_AUX_SC_BIT] = 1'b0;
      sta_nxt[`HV_STA_WAKE_EDGE_BIT] = 1'b0;
      sta_nxt[`HV_STA_WAKE_SC_BIT] = 1'b0;
      sta_nxt[`HV_STA_THERM_BIT] = 1'b0;
    end
    // events set after the clear so they win
    if (cfg_in.input_mode && line_edge[1]) begin
      sta_nxt[`HV_STA_WAKE_EDGE_BIT] = 1'b1;
    end
    if (fault_in.thermal) begin
      sta_nxt[`HV_STA_THERM_BIT] = 1'b1;
    end
    if (fault_in.bus_short) begin
      sta_nxt[`HV_STA_BUS_SC_BIT] = 1'b1;
    end
    if (fault_in.aux_short) begin
      sta_nxt[`HV_STA_AUX_SC_BIT] = 1'b1;
    end
    if (fault_in.wake_short) begin
      sta_nxt[`HV_STA_WAKE_SC_BIT] = 1'b1;
    end
    // supply monitor is live, not latched
    sta_nxt[`HV_STA_SUPPLY_BIT] = cfg_in.supply_mon_en
                                  & fault_in.supply_low;
    sta_nxt[7:6] = 2'h0; // reserved
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sta_r <= `HV_EVENT_STATUS_RST;
    end else begin
      sta_r <= sta_nxt;
    end
  end

  // any new event: latched bit rising, edge in input mode, supply drop
  assign event_any = (|(sta_nxt[4:0] & ~sta_r[4:0]))
                     | (cfg_in.input_mode & (|line_edge))
                     | (sta_nxt[`HV_STA_SUPPLY_BIT]
                        & ~sta_r[`HV_STA_SUPPLY_BIT]);

  // -------------------------------------------------------------------------
  // interrupt request
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hv_irq_line_out <= 1'b0;
    end else begin
      hv_irq_line_out <= irq_enable_in & event_any;
    end
  end

  // -------------------------------------------------------------------------
  // automatic transfer and busy handshake
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      xfer_r <= xfer_idle;
      cnt_r <= '0;
      busy_out <= 1'b0;
      xfer_ok_out <= 1'b0;
    end else begin
      unique case (xfer_r)
        xfer_idle: begin
          if (irq_enable_in && event_any) begin
            xfer_r <= xfer_busy;
            cnt_r <= `HV_XFER_CNT_W'(`HV_XFER_CYCLES - 1);
            busy_out <= 1'b1;
            xfer_ok_out <= 1'b0;
          end
        end
        xfer_busy: begin
          if (cnt_r == '0) begin
            xfer_r <= xfer_idle;
            busy_out <= 1'b0;
            xfer_ok_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // data port: status snapshot on interrupt, else indirect reads
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hv_data_port_out <= 8'h00;
    end else if (xfer_r == xfer_idle && irq_enable_in && event_any) begin
      hv_data_port_out <= sta_nxt;
    end else if (rd_req_in && xfer_r == xfer_idle) begin
      hv_data_port_out <= (rd_sel_in == `HV_SEL_EVENT_STATUS) ? sta_r
                                                             : mon_r;
    end
  end

  // -------------------------------------------------------------------------
  // driver enables and self-clearing re-enable bit
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drv_en_out <= '1;
      reenable_bit_out <= 1'b0;
    end else begin
      reenable_bit_out <= drv_reenable_in;
      if (fault_in.thermal) begin
        drv_en_out <= '0;
      end else begin
        if (fault_in.bus_short) begin
          drv_en_out.bus_drv <= 1'b0;
        end else if (drv_reenable_in) begin
          drv_en_out.bus_drv <= 1'b1;
        end
        if (fault_in.aux_short) begin
          drv_en_out.aux_drv <= 1'b0;
        end else if (drv_reenable_in) begin
          drv_en_out.aux_drv <= 1'b1;
        end
        if (fault_in.wake_short) begin
          drv_en_out.wake_drv <= 1'b0;
        end else if (drv_reenable_in) begin
          drv_en_out.wake_drv <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  sequence s_xfer_start;
    (xfer_r == xfer_idle) && irq_enable_in && event_any;
  endsequence

  sequence s_busy_window;
    busy_out [*8];
  endsequence

  // cycles spent busy, lets the checks bound the transfer time
  logic [`HV_XFER_CNT_W-1:0] busy_len_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_len_r <= '0;
    end else begin
      busy_len_r <= busy_out ? busy_len_r + 1'b1 : '0;
    end
  end

  a_busy_after_irq: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_xfer_start |=> s_busy_window)
    else $error("busy not held after status transfer start");

  a_busy_ends: assert property (@(posedge clk_in) disable iff (!nrst_in)
    busy_out ? (busy_len_r < `HV_XFER_CYCLES)
             : (busy_len_r == '0
                || busy_len_r == `HV_XFER_CYCLES))
    else $error("busy did not end after transfer time");

  a_data_snapshot: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_xfer_start |=> hv_data_port_out == $past(sta_nxt))
    else $error("status not copied to data port");

  a_thermal_drv_off: assert property (@(posedge clk_in)
    disable iff (!nrst_in)
    fault_in.thermal |=> drv_en_out == 3'h0)
    else $error("drivers not disabled on thermal event");

  a_therm_status: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fault_in.thermal |=> sta_r[`HV_STA_THERM_BIT] ##1
    mon_r[`HV_MON_THERM_BIT])
    else $error("thermal event not recorded");

  a_bus_short_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fault_in.bus_short |=> sta_r[`HV_STA_BUS_SC_BIT]
    && !drv_en_out.bus_drv)
    else $error("bus short not flagged");

  a_aux_read_clr: assert property (@(posedge clk_in) disable iff (!nrst_in)
    sta_rd && !fault_in.aux_short |=> !sta_r[`HV_STA_AUX_SC_BIT])
    else $error("aux short bit not cleared by read");

  a_wake_follow: assert property (@(posedge clk_in) disable iff (!nrst_in)
    cfg_in.input_mode |=> mon_r[`HV_MON_WAKE_BIT]
    == $past(wake_line_in))
    else $error("monitor bit 7 not following wake line");

  a_aux_follow: assert property (@(posedge clk_in) disable iff (!nrst_in)
    cfg_in.input_mode |=> mon_r[`HV_MON_AUX_BIT]
    == $past(aux_hv_line_in))
    else $error("monitor bit 5 not following aux line");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    sta_r[7:6] == 2'h0)
    else $error("reserved status bits set");

  a_supply_live: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !cfg_in.supply_mon_en |=> !sta_r[`HV_STA_SUPPLY_BIT])
    else $error("supply bit set while monitor disabled");

endmodule // hv_monitor_status_regs

// [dv/hv_pin_model.sv]
// behavioural pin drivers and supervisory circuits around the hv block
module hv_pin_model
  import hv_mon_pkg::*;
(
  input wire logic clk_in,
  input wire hv_drv_type drv_en_in,
  input wire hv_fault_type cond_in,
  input wire logic wake_lvl_in,
  input wire logic aux_lvl_in,
  input wire logic supply_ok_in,
  output hv_fault_type fault_out,
  output logic wake_line_out,
  output logic aux_hv_line_out,
  output logic core_supply_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------
  // supervisory detectors
  // --------------------
  // a driver reports a short only while it is switched on
  always_ff @(posedge clk_in) begin
    fault_out.thermal <= cond_in.thermal;
    fault_out.bus_short <= cond_in.bus_short & drv_en_in.bus_drv;
    fault_out.aux_short <= cond_in.aux_short & drv_en_in.aux_drv;
    fault_out.wake_short <= cond_in.wake_short & drv_en_in.wake_drv;
    fault_out.supply_low <= cond_in.supply_low;
  end

  // line levels and the core comparator pass straight through
  assign wake_line_out = wake_lvl_in;
  assign aux_hv_line_out = aux_lvl_in;
  assign core_supply_ok_out = supply_ok_in;
endmodule // hv_pin_model

// [dv/testbench.sv]
// self-checking bench for the hv monitor and status registers
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[ERR] %s exp %h got %h", nm, exp, got); \
    end \
  end

module testbench;
  import hv_mon_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------
  // signals and tables
  // --------------------
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  hv_cfg_type cfg = '0;
  hv_fault_type cond = '0;
  hv_fault_type fault;
  hv_drv_type drv;
  logic wake_lvl = 1'b0;
  logic aux_lvl = 1'b0;
  logic supply_ok = 1'b1;
  logic reen = 1'b0;
  logic irq_en = 1'b0;
  logic rd_req = 1'b0;
  logic rd_sel = 1'b0;
  logic wake_ln, aux_ln, sup_ok, busy, ok, irq, reen_bit;
  logic [7:0] dat, d;
  logic [31:0] r;
  int seed, n, h, cycles, fail_count, total_checks;
  // per case: stimulus {wake toggle, fault bits}, status, monitor, drivers
  logic [5:0] stim_tab [6] = '{6'h08, 6'h04, 6'h02, 6'h10, 6'h01, 6'h20};
  logic [7:0] sta_tab [6] = '{8'h04, 8'h02, 8'h01, 8'h08, 8'h20, 8'h10};
  logic [7:0] mon_tab [6] = '{8'h04, 8'h02, 8'h01, 8'h40, 8'h00, 8'h00};
  logic [2:0] dmask_tab [6] = '{3'b100, 3'b000, 3'b000, 3'b111, 3'b000,
                                3'b000};

  always #5 clk_in = ~clk_in;

  hv_monitor_status_regs u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg), .fault_in(fault),
    .wake_line_in(wake_ln), .aux_hv_line_in(aux_ln),
    .core_supply_ok_in(sup_ok), .drv_reenable_in(reen),
    .irq_enable_in(irq_en), .rd_req_in(rd_req), .rd_sel_in(rd_sel),
    .drv_en_out(drv), .hv_data_port_out(dat), .busy_out(busy),
    .xfer_ok_out(ok), .hv_irq_line_out(irq), .reenable_bit_out(reen_bit)
  );

  hv_pin_model u_pins (
    .clk_in(clk_in), .drv_en_in(drv), .cond_in(cond),
    .wake_lvl_in(wake_lvl), .aux_lvl_in(aux_lvl), .supply_ok_in(supply_ok),
    .fault_out(fault), .wake_line_out(wake_ln), .aux_hv_line_out(aux_ln),
    .core_supply_ok_out(sup_ok)
  );

  // --------------------
  // helpers
  // --------------------
  function automatic logic [7:0] mon_exp(input logic w, a, b, l);
    return {w, 1'b0, a, b, l, 3'b000};
  endfunction

  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  // indirect read, data lands on the edge that takes the request
  task automatic rd(input logic sel, output logic [7:0] v);
    rd_req = 1'b1;
    rd_sel = sel;
    cyc(1);
    rd_req = 1'b0;
    cyc(1);
    v = dat;
  endtask

  task automatic reenable();
    reen = 1'b1;
    cyc(1);
    reen = 1'b0;
    h = 0;
    repeat (4) begin
      if (reen_bit === 1'b1) h++;
      cyc(1);
    end
    `CHK("reenable_pulse", 1, h)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, the whole run needs under 8000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // --------------------
  // main sequence
  // --------------------
  initial begin
    seed = 32'h6A9272CE;
    repeat (5) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    `CHK("drv_reset", 3'b111, drv)
    rd(1'b0, d);
    `CHK("mon_reset", 8'h00, d)
    rd(1'b1, d);
    `CHK("sta_reset", 8'h00, d)
    $display("test reset done");
    // live levels with random lines, supply dip mid-way
    cfg.input_mode = 1'b1;
    cfg.low_flag_en = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wake_lvl = r[0];
      aux_lvl = r[1];
      cfg.buf_en = r[2];
      if (i == 4) supply_ok = 1'b0;
      if (i == 6) supply_ok = 1'b1;
      cyc(4);
      rd(1'b0, d);
      `CHK("mon_live", mon_exp(r[0], r[1], r[2], i < 4), d)
    end
    cfg.low_flag_en = 1'b0;
    cyc(3);
    cfg.low_flag_en = 1'b1;
    cyc(4);
    rd(1'b0, d);
    `CHK("low_rearm", 1'b1, d[3])
    rd(1'b1, d);
    $display("test monitor done");
    // masked interrupt: flag latches, no request
    cond.aux_short = 1'b1;
    h = 0;
    repeat (8) begin
      if (irq === 1'b1) h++;
      cyc(1);
    end
    cond = '0;
    `CHK("irq_masked", 0, h)
    rd(1'b1, d);
    `CHK("sta_masked", 1'b1, d[1])
    reenable();
    $display("test masked done");
    // each status event source with automatic transfer
    irq_en = 1'b1;
    cfg.supply_mon_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      cond = hv_fault_type'(stim_tab[k][4:0]);
      if (stim_tab[k][5]) wake_lvl = ~wake_lvl;
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
        cyc(1);
        n++;
      end
      cond = hv_fault_type'(stim_tab[k][4:0] & 5'h01);
      `CHK("irq_seen", 1'b1, irq)
      `CHK("xfer_busy", 1'b1, busy)
      `CHK("xfer_ok_low", 1'b0, ok)
      `CHK("xfer_data", sta_tab[k], dat & sta_tab[k])
      d = dat;
      rd_req = 1'b1;
      rd_sel = 1'b0;
      cyc(1);
      rd_req = 1'b0;
      cyc(1);
      `CHK("rd_refused", d, dat)
      n = 2;
      do begin
        n++;
        cyc(1);
      end while (busy === 1'b1 && n < 1100);
      `CHK("busy_len", 1000, n)
      `CHK("xfer_ok", 1'b1, ok)
      `CHK("drv_off", 3'b000, drv & dmask_tab[k])
      rd(1'b0, d);
      `CHK("mon_flag", mon_tab[k], d & mon_tab[k])
      rd(1'b1, d);
      `CHK("sta_flag", sta_tab[k], d & sta_tab[k])
      rd(1'b1, d);
      `CHK("sta_clear", 8'h00, d & 8'h1F)
      cond = '0;
      reenable();
      cyc(3);
      `CHK("drv_on", 3'b111, drv)
      rd(1'b0, d);
      `CHK("mon_clear", 8'h00, d & 8'h47)
    end
    $display("test events done");
    report_and_stop();
  end
endmodule // testbench
